// ---- sfl_bus_master.sv ----
/*
  Behavioural master on the two-wire bus: START, STOP and single bits.
  Assumes the caller is aligned just after a rising edge of clk.
*/
`timescale 1ns/1ps
module sfl_bus_master
  import sfl_pkg::*;
(
  // Clock
  input wire logic clk,
  // Bus lines, driven high when idle
  output logic scl,
  output logic sda
);
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // 400 ns link period at a 50 ns module clock
  localparam int HALF = LINK_HALF_CYC;

  initial
  begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic half_bit();
    repeat (HALF) @(posedge clk);
  endtask

  // ----------------------------------------
  // Bus conditions
  // ----------------------------------------
  // Clock stands high between frames
  task automatic start_cond();
    sda <= 1'b0;
    half_bit();
    scl <= 1'b0;
    half_bit();
  endtask

  // Data moves one clock after the falling edge, never beside it
  task automatic put_bit(input logic b);
    sda <= b;
    half_bit();
    scl <= 1'b1;
    half_bit();
    scl <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stop_cond();
    sda <= 1'b0;
    half_bit();
    scl <= 1'b1;
    half_bit();
    sda <= 1'b1;
    half_bit();
  endtask
endmodule

// ---- sfl_bus_mon.sv ----
/*
  Pin monitor: synchronises the bus clock and data lines, finds START,
  STOP and rising clock edges, shifts bytes and marks byte and ack bits.
  Assumes the bus clock is much slower than the module clock.
*/
`timescale 1ns/1ps
module sfl_bus_mon
  import sfl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Events out
  sfl_link_if.mon lk
);
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt;
  logic [6:0] shreg;
  logic rise;
  logic start_c;
  logic stop_c;

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // Idle bus is high, so reset to ones
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[0], scl_pin};
      sda_s <= {sda_s[0], sda_pin};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end

  assign rise = !scl_q && scl_s[1];
  assign start_c = scl_q && scl_s[1] && sda_q && !sda_s[1];
  assign stop_c = scl_q && scl_s[1] && !sda_q && sda_s[1];

  // ----------------------------------------
  // Bit counter and shifter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 4'h0;
      shreg <= 7'h00;
      lk.start_det <= 1'b0;
      lk.stop_det <= 1'b0;
      lk.bit0_stb <= 1'b0;
      lk.byte_stb <= 1'b0;
      lk.ack_stb <= 1'b0;
      lk.ack_bit <= 1'b1;
      lk.first_byte <= 1'b0;
      lk.byte_val <= REG_RST;
    end
    else
    begin
      lk.start_det <= start_c;
      lk.stop_det <= stop_c;
      lk.bit0_stb <= 1'b0;
      lk.byte_stb <= 1'b0;
      lk.ack_stb <= 1'b0;
      if (start_c || stop_c)
      begin
        cnt <= 4'h0;
        lk.first_byte <= start_c;
      end
      else if (rise)
      begin
        if (cnt == BITS_PER_BYTE)
        begin
          cnt <= 4'h0;
          lk.ack_stb <= 1'b1;
          lk.ack_bit <= sda_s[1];
          lk.first_byte <= 1'b0;
        end
        else
        begin
          cnt <= cnt + 4'h1;
          shreg <= {shreg[5:0], sda_s[1]};
          lk.bit0_stb <= (cnt == 4'h0);
          if (cnt == BITS_PER_BYTE - 4'h1)
          begin
            lk.byte_stb <= 1'b1;
            lk.byte_val <= {shreg, sda_s[1]};
          end
        end
      end
    end
  end
endmodule

// ---- sfl_link_if.sv ----
/*
  Carries bus events from the pin monitor to the status core.
  Assumes both ends run on the same module clock.
*/
`timescale 1ns/1ps
interface sfl_link_if;
  logic start_det;
  logic stop_det;
  logic bit0_stb;
  logic byte_stb;
  logic ack_stb;
  logic ack_bit;
  logic first_byte;
  logic [7:0] byte_val;
  modport mon (output start_det, stop_det, bit0_stb, byte_stb, ack_stb, ack_bit,
    first_byte, byte_val);
  modport core (input start_det, stop_det, bit0_stb, byte_stb, ack_stb, ack_bit,
    first_byte, byte_val);
endinterface

// ---- sfl_pkg.sv ----
/*
  Constants for the two-wire bus status flag logic: register offsets,
  bit positions, reset values and the fixed bus addresses.
  Assumes a 4-bit register address and 8-bit register data.
*/
package sfl_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_ADDR1 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h2;
  localparam logic [3:0] OFS_STAT = 4'h3;
  localparam logic [3:0] OFS_DATA = 4'h4;
  localparam logic [3:0] OFS_ADDR2 = 4'h5;
  localparam logic [3:0] OFS_RANGE = 4'h6;
  localparam logic [3:0] OFS_ACTL = 4'h7;
  localparam logic [3:0] OFS_IST = 4'h8;
  localparam logic [3:0] OFS_IMSK = 4'h9;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ST_DONE = 7;
  localparam int ST_SEL = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_DIR = 2;
  localparam int CT_TX = 4;
  localparam int AC_GC = 0;
  localparam int AC_ALERT = 1;
  localparam int AC_SEC = 2;
  localparam int AC_RANGE = 3;
  localparam int EV_DONE = 0;
  localparam int EV_SEL = 1;
  localparam int EV_START = 2;
  localparam int EV_STOP = 3;
  // ----------------------------------------
  // Reset values and bus constants
  // ----------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [6:0] ALERT_ADDR = 7'h0c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int LINK_PERIOD_NS = 400;
  localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
endpackage

// ---- sfl_status_core.sv ----
/*
  Status flag logic of a two-wire bus slave: byte-done, selected-as-slave
  and bus-busy flags, address matching, registers and interrupt.
  Assumes a simple strobe register port and slow bus pins.
*/
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module sfl_status_core
  import sfl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Interrupt
  output logic irq
);
  typedef enum logic [1:0] {SFL_IDLE, SFL_ADDR, SFL_MINE, SFL_OTHER} sfl_state_t;

  sfl_state_t st;
  logic [7:0] primary_slave_addr;
  logic [7:0] control_reg_one;
  logic [7:0] second_slave_addr;
  logic [7:0] range_slave_addr;
  logic [7:0] addr_ctrl;
  logic [7:0] rx_data;
  logic [7:0] tx_data;
  logic [3:0] ist;
  logic [3:0] imsk;
  logic byte_done_flag;
  logic slave_selected_flag;
  logic busy_flag;
  logic slave_direction_bit;
  logic [7:0] stat;
  logic [6:0] ca;
  logic m_pri;
  logic m_rng;
  logic m_gc;
  logic m_sec;
  logic m_alr;
  logic m_rm;
  logic addr_byte;
  logic match;
  logic done_set;
  logic done_clr;
  logic sel_clr;
  logic [3:0] ev;

  sfl_link_if lk ();

  sfl_bus_mon u_mon (
    .clk(clk),
    .rst_n(rst_n),
    .scl_pin(scl_pin),
    .sda_pin(sda_pin),
    .lk(lk)
  );

  // ----------------------------------------
  // Address matching
  // ----------------------------------------
  assign ca = lk.byte_val[7:1];
  assign addr_byte = lk.byte_stb && lk.first_byte && (st == SFL_ADDR);
  assign m_pri = (ca == primary_slave_addr[7:1]);
  assign m_rng = (range_slave_addr[7:1] != 7'h00) && (ca == range_slave_addr[7:1]);
  assign m_gc = addr_ctrl[AC_GC] && (ca == GC_ADDR);
  assign m_sec = addr_ctrl[AC_SEC] && (ca == second_slave_addr[7:1]);
  assign m_alr = addr_ctrl[AC_ALERT] && (ca == ALERT_ADDR);
  assign m_rm = addr_ctrl[AC_RANGE] && (ca > primary_slave_addr[7:1])
    && (ca < range_slave_addr[7:1]);
  assign match = addr_byte && (m_pri || m_rng || m_gc || m_sec || m_alr || m_rm);

  // ----------------------------------------
  // Transaction state
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= SFL_IDLE;
    else if (lk.start_det)
      st <= SFL_ADDR;
    else if (lk.stop_det)
      st <= SFL_IDLE;
    else if (addr_byte)
      st <= match ? SFL_MINE : SFL_OTHER;
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // all flags reset low
  assign done_set = match || (lk.ack_stb && (st == SFL_MINE));
  assign done_clr = lk.bit0_stb
    || (rd && (addr == OFS_DATA) && !control_reg_one[CT_TX])
    || (wr && (addr == OFS_DATA) && control_reg_one[CT_TX]);
  assign sel_clr = wr && (addr == OFS_CTRL1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      byte_done_flag <= 1'b0;
    else if (done_set)
      byte_done_flag <= 1'b1;
    else if (done_clr)
      byte_done_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_selected_flag <= 1'b0;
      slave_direction_bit <= 1'b0;
    end
    else if (match)
    begin
      slave_selected_flag <= 1'b1;
      slave_direction_bit <= lk.byte_val[0];
    end
    else if (sel_clr)
      slave_selected_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_flag <= 1'b0;
    else if (lk.start_det)
      busy_flag <= 1'b1;
    else if (lk.stop_det)
      busy_flag <= 1'b0;
  end

  always_comb
  begin
    stat = REG_RST;
    stat[ST_DONE] = byte_done_flag;
    stat[ST_SEL] = slave_selected_flag;
    stat[ST_BUSY] = busy_flag;
    stat[ST_DIR] = slave_direction_bit;
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primary_slave_addr <= REG_RST;
      control_reg_one <= REG_RST;
      second_slave_addr <= REG_RST;
      range_slave_addr <= REG_RST;
      addr_ctrl <= REG_RST;
      tx_data <= REG_RST;
      imsk <= 4'h0;
    end
    else if (wr)
    begin
      unique case (addr)
        OFS_ADDR1: primary_slave_addr <= wdata;
        OFS_CTRL1: control_reg_one <= wdata;
        OFS_ADDR2: second_slave_addr <= wdata;
        OFS_RANGE: range_slave_addr <= wdata;
        OFS_ACTL: addr_ctrl <= wdata;
        OFS_DATA: tx_data <= wdata;
        OFS_IMSK: imsk <= wdata[3:0];
        default: ;
      endcase
    end
  end

  // Only data bytes of our own transfer land here
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_data <= REG_RST;
    else if (lk.byte_stb && (st == SFL_MINE))
      rx_data <= lk.byte_val;
  end

  // ----------------------------------------
  // Interrupt status, cleared by read
  // ----------------------------------------
  always_comb
  begin
    ev = 4'h0;
    ev[EV_DONE] = done_set;
    ev[EV_SEL] = match;
    ev[EV_START] = lk.start_det;
    ev[EV_STOP] = lk.stop_det;
  end

  // New events win over the clearing read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ist <= 4'h0;
    else if (rd && (addr == OFS_IST))
      ist <= ev;
    else
      ist <= ist | ev;
  end

  assign irq = |(ist & imsk);

  // ----------------------------------------
  // Read data, valid one cycle after strobe
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= REG_RST;
    else if (!rd)
      rdata <= REG_RST;
    else
    begin
      unique case (addr)
        OFS_ADDR1: rdata <= primary_slave_addr;
        OFS_CTRL1: rdata <= control_reg_one;
        OFS_STAT: rdata <= stat;
        OFS_DATA: rdata <= rx_data;
        OFS_ADDR2: rdata <= second_slave_addr;
        OFS_RANGE: rdata <= range_slave_addr;
        OFS_ACTL: rdata <= addr_ctrl;
        OFS_IST: rdata <= {4'h0, ist};
        OFS_IMSK: rdata <= {4'h0, imsk};
        default: rdata <= REG_RST;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_addr_hit;
    addr_byte && m_pri;
  endsequence
  sequence s_flags_up;
    slave_selected_flag && byte_done_flag && !lk.ack_stb;
  endsequence

  property p_done_ack;
    lk.ack_stb && (st == SFL_MINE) |=> byte_done_flag;
  endproperty
  a_done_ack: assert property (p_done_ack) else $error("byte done not set on ack");

  property p_done_clr;
    (rd && (addr == OFS_DATA) && !control_reg_one[CT_TX]) && !done_set |=> !byte_done_flag;
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("byte done not cleared");

  property p_pri_both;
    s_addr_hit |=> s_flags_up;
  endproperty
  a_pri_both: assert property (p_pri_both) else $error("primary match flags");

  property p_gc;
    addr_byte && addr_ctrl[AC_GC] && (ca == GC_ADDR) |=> slave_selected_flag;
  endproperty
  a_gc: assert property (p_gc) else $error("general call not seen");

  property p_sec;
    addr_byte && addr_ctrl[AC_SEC] && (ca == second_slave_addr[7:1])
      |=> slave_selected_flag && (st == SFL_MINE);
  endproperty
  a_sec: assert property (p_sec) else $error("second address not seen");

  property p_alert;
    addr_byte && addr_ctrl[AC_ALERT] && (ca == ALERT_ADDR) |=> slave_selected_flag;
  endproperty
  a_alert: assert property (p_alert) else $error("alert address not seen");

  property p_range;
    addr_byte && addr_ctrl[AC_RANGE] && (ca > primary_slave_addr[7:1])
      && (ca < range_slave_addr[7:1]) |=> slave_selected_flag && (st == SFL_MINE);
  endproperty
  a_range: assert property (p_range) else $error("range address missed");

  property p_before_ack;
    match |=> (slave_selected_flag && !lk.ack_stb) ##1 !lk.ack_stb;
  endproperty
  a_before_ack: assert property (p_before_ack) else $error("selected after ack");

  property p_sel_clr;
    sel_clr && !match |=> !slave_selected_flag;
  endproperty
  a_sel_clr: assert property (p_sel_clr) else $error("selected not cleared");

  property p_busy;
    lk.start_det |=> busy_flag [*2] or (busy_flag ##1 lk.stop_det);
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set on start");

  property p_idle;
    lk.stop_det && !lk.start_det |=> !busy_flag;
  endproperty
  a_idle: assert property (p_idle) else $error("busy not cleared on stop");

  property p_reset_zero;
    $rose(rst_n) |-> (stat == REG_RST) && !irq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("flags not zero");
endmodule

// ---- tb.sv ----
/*
  Self-checking bench for the status flag logic: register port, flags,
  address sources and interrupt.
  Assumes the bus master model sfl_bus_master.
*/
`timescale 1ns/1ps
module tb
  import sfl_pkg::*;
();
  logic clk, rst_n, scl_pin, sda_pin, wr, rd, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  int fail_count, cmp_count, cyc;
  logic [6:0] pa, ra, sa;
  logic ld;

  // ----------------------------------------
  // Clock, instances, timeout
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  sfl_bus_master u_sfl_bus_master (.clk(clk), .scl(scl_pin), .sda(sda_pin));

  sfl_status_core u_sfl_status_core (.clk(clk), .rst_n(rst_n), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq));

  // Ceiling well above the roughly 1650 cycles the frames need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Tasks and functions
  // ----------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] stat(input logic done, sel, busy, dir);
    return {done, sel, busy, 2'b00, dir, 2'b00};
  endfunction

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic send_bits(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      u_sfl_bus_master.put_bit(b[i]);
    settle();
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
  endtask

  task automatic xfer(input logic dir);
    logic [7:0] d;
    logic [7:0] v;
    d = 8'($urandom);
    u_sfl_bus_master.start_cond();
    settle();
    rreg(OFS_STAT, v);
    check("busy", v, stat(1'b0, 1'b0, 1'b1, ld));
    send_bits({pa, dir});
    rreg(OFS_STAT, v);
    check("addressed", v, stat(1'b1, 1'b1, 1'b1, dir));
    ld = dir;
    u_sfl_bus_master.put_bit(1'b0);
    wreg(OFS_CTRL1, {3'h0, dir, 4'h0});
    rreg(OFS_STAT, v);
    check("ctrl write", v, stat(1'b1, 1'b0, 1'b1, dir));
    if (dir)
    begin
      wreg(OFS_DATA, d);
      rreg(OFS_STAT, v);
      check("tx clear", v, stat(1'b0, 1'b0, 1'b1, 1'b1));
    end
    send_bits(d);
    u_sfl_bus_master.put_bit(1'b0);
    settle();
    rreg(OFS_STAT, v);
    check("byte done", v, stat(1'b1, 1'b0, 1'b1, dir));
    if (!dir)
    begin
      rreg(OFS_DATA, v);
      check("rx data", v, d);
      rreg(OFS_STAT, v);
      check("rx clear", v, stat(1'b0, 1'b0, 1'b1, 1'b0));
    end
    u_sfl_bus_master.stop_cond();
    settle();
    rreg(OFS_STAT, v);
    check("idle", v & 8'h20, 8'h00);
    @(negedge clk);
    check("irq up", {7'h00, irq}, 8'h01);
    @(posedge clk);
    rreg(OFS_IST, v);
    check("events", v, 8'h0f);
    @(negedge clk);
    check("irq down", {7'h00, irq}, 8'h00);
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] v;
    logic [7:0] m;
    logic dr;
    logic [6:0] ca [10];
    logic [3:0] cm [10];
    logic ce [10];
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    v = $urandom(99640);
    reset_dut();
    for (int i = 0; i < 16; i++)
    begin
      rreg(4'(i), v);
      check("reset value", v, REG_RST);
    end
    pa = 7'h20 + 7'($urandom_range(31));
    ra = pa + 7'h4;
    sa = 7'h50 + 7'($urandom_range(31));
    wreg(OFS_ADDR1, {pa, 1'b0});
    wreg(OFS_RANGE, {ra, 1'b0});
    wreg(OFS_ADDR2, {sa, 1'b0});
    ca = '{pa, ra, pa + 7'h2, pa + 7'h2, GC_ADDR, GC_ADDR, sa, sa, ALERT_ADDR, ALERT_ADDR};
    cm = '{4'h0, 4'h0, 4'h0, 4'h8, 4'h1, 4'h0, 4'h4, 4'h0, 4'h2, 4'h0};
    ce = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    // Masked events must leave the interrupt low
    wreg(OFS_IMSK, 8'h00);
    for (int k = 0; k < 10; k++)
    begin
      dr = 1'($urandom);
      wreg(OFS_ACTL, {4'h0, cm[k]});
      wreg(OFS_CTRL1, 8'h00);
      u_sfl_bus_master.start_cond();
      send_bits({ca[k], dr});
      // done and direction unchecked without a match
      m = ce[k] ? 8'hff : 8'h7b;
      rreg(OFS_STAT, v);
      check("match", v & m, stat(ce[k], ce[k], 1'b1, dr) & m);
      // Direction stays from the last match
      if (ce[k])
        ld = dr;
      u_sfl_bus_master.put_bit(!ce[k]);
      u_sfl_bus_master.stop_cond();
      settle();
      @(negedge clk);
      check("irq masked", {7'h00, irq}, 8'h00);
      @(posedge clk);
      rreg(OFS_IST, v);
      check("masked events", v, ce[k] ? 8'h0f : 8'h0c);
    end
    wreg(OFS_ACTL, 8'h00);
    wreg(OFS_IMSK, 8'h0f);
    xfer(1'b0);
    xfer(1'b1);
    // Second reset after flags were left set
    reset_dut();
    rreg(OFS_STAT, v);
    check("second reset", v, 8'h00);
    end_of_test();
  end
endmodule
